//--- design/sbs_buf_if.sv
/*
 * sbs_buf_if: carries one slip buffer's ports between the status top and the buffer.
 * assumes: single clock, each strobe high one cycle per transfer.
 */
`timescale 1ns/1ps
`default_nettype none
interface sbs_buf_if;
    import sbs_pkg::*;
    logic wr_valid;
    logic [SBS_DATA_W-1:0] wr_data;
    logic rd_en;
    logic [SBS_DATA_W-1:0] rd_data;
    logic overflow;
    logic underflow;

    modport buffer (input wr_valid, input wr_data, input rd_en,
                    output rd_data, output overflow, output underflow);
    modport user (output wr_valid, output wr_data, output rd_en,
                  input rd_data, input overflow, input underflow);
endinterface : sbs_buf_if
`default_nettype wire

//--- design/sbs_lock_tracker.sv
/*
 * sbs_lock_tracker: declares and drops multiframe lock from pattern checks.
 * assumes: ok and err are one-cycle pulses, one per received alignment pattern.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_lock_tracker
    import sbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // configuration
    input wire logic enable_i,
    input wire logic confirm_sel_i,
    input wire logic [SBS_THR_W-1:0] loss_thr_i,
    // pattern checks
    input wire logic align_ok_i,
    input wire logic align_err_i,
    // status
    output logic locked_o
);
    // =========================================================
    // lock state machine
    // =========================================================
    sbs_lock_state_e state_q, state_d;
    logic [SBS_THR_W:0] err_q, err_d;
    logic [SBS_THR_W:0] limit;

    // field value n means n+1 consecutive errored patterns
    assign limit = {1'b0, loss_thr_i} + {{SBS_THR_W{1'b0}}, 1'b1};

    always_comb begin
        state_d = state_q;
        err_d = err_q;
        case (state_q)
            SBS_HUNT: begin
                err_d = '0;
                if (align_ok_i) begin
                    state_d = confirm_sel_i ? SBS_CONFIRM : SBS_LOCKED;
                end
            end
            SBS_CONFIRM: begin
                if (align_ok_i) begin
                    state_d = SBS_LOCKED;
                end else if (align_err_i) begin
                    state_d = SBS_HUNT;
                end
            end
            SBS_LOCKED: begin
                if (align_err_i) begin
                    err_d = err_q + {{SBS_THR_W{1'b0}}, 1'b1};
                    if (err_d == limit) begin
                        state_d = SBS_HUNT;
                    end
                end else if (align_ok_i) begin
                    err_d = '0; // a good pattern breaks the run
                end
            end
            default: state_d = SBS_HUNT;
        endcase
        // with alignment off the tracker just idles in hunt
        if (!enable_i) begin
            state_d = SBS_HUNT;
            err_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q <= SBS_HUNT;
            err_q <= '0;
        end else begin
            state_q <= state_d;
            err_q <= err_d;
        end
    end

    assign locked_o = (state_q == SBS_LOCKED);
endmodule : sbs_lock_tracker
`default_nettype wire

//--- design/sbs_pkg.sv
/*
 * sbs_pkg: shared constants for the slip buffer status block.
 * assumes: an 8-bit register port and E1 frames of 32 octets.
 */
package sbs_pkg;
    // =========================================================
    // register map
    // =========================================================
    localparam logic [7:0] SBS_ADDR_STATUS = 8'h08; // slip_event_status
    localparam logic [7:0] SBS_ADDR_MASK = 8'h09;
    localparam logic [7:0] SBS_ADDR_FRAMING = 8'h0a;
    localparam logic [7:0] SBS_RESET_VAL = 8'h00;

    // =========================================================
    // slip_event_status fields
    // =========================================================
    localparam int SBS_BIT_TX_OVF = 7;
    localparam int SBS_BIT_TX_UNF = 6;
    localparam int SBS_BIT_TX_SLIP = 5;
    localparam int SBS_BIT_CAS_LOCK = 4;
    localparam int SBS_BIT_CRC_LOCK = 3;
    localparam int SBS_BIT_RX_OVF = 2;
    // sticky bits; the lock bits are live and never stored
    localparam logic [7:0] SBS_STICKY_MASK = 8'he4;

    // =========================================================
    // framing register fields
    // =========================================================
    localparam int SBS_FR_CAS_EN = 0;
    localparam int SBS_FR_CRC_EN = 1;
    localparam int SBS_FR_CAS_SEL = 2;
    localparam int SBS_FR_CRC_SEL = 3;
    localparam int SBS_FR_CAS_THR_LO = 4;
    localparam int SBS_FR_CRC_THR_LO = 6;
    localparam int SBS_THR_W = 2;

    // =========================================================
    // buffer geometry
    // =========================================================
    localparam int SBS_DATA_W = 8;
    localparam int SBS_FRAME_LEN = 32;
    localparam int SBS_FRAMES = 2;
    localparam int SBS_DEPTH = SBS_FRAME_LEN * SBS_FRAMES;
    localparam int SBS_PTR_W = 6;
    localparam int SBS_CNT_W = 7;
    localparam logic [SBS_PTR_W-1:0] SBS_FRAME_STEP = 6'h20;
    localparam logic [SBS_CNT_W-1:0] SBS_FRAME_CNT = 7'h20;
    localparam logic [SBS_CNT_W-1:0] SBS_FULL_CNT = 7'h40;
    localparam logic [SBS_CNT_W-1:0] SBS_EMPTY_CNT = 7'h00;

    // lock tracker states
    typedef enum logic [1:0] {SBS_HUNT, SBS_CONFIRM, SBS_LOCKED} sbs_lock_state_e;
endpackage : sbs_pkg

//--- design/sbs_slip_buffer.sv
/*
 * sbs_slip_buffer: two-frame elastic store that slips by whole frames.
 * assumes: writer and reader share clk_i; the reader never waits.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_slip_buffer
    import sbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // buffer ports
    sbs_buf_if.buffer bus
);
    // =========================================================
    // storage and pointers
    // =========================================================
    logic [SBS_DATA_W-1:0] mem_q [SBS_DEPTH];
    logic [SBS_DATA_W-1:0] mem_d [SBS_DEPTH];
    logic [SBS_PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [SBS_CNT_W-1:0] cnt_q, cnt_d;
    logic [SBS_DATA_W-1:0] rd_data_q, rd_data_d;
    logic ovf_q, ovf_d, unf_q, unf_d;

    // next state: a slip moves the read pointer a full frame before the access
    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        rd_data_d = rd_data_q;
        ovf_d = bus.wr_valid && (cnt_q == SBS_FULL_CNT);
        unf_d = bus.rd_en && (cnt_q == SBS_EMPTY_CNT);
        if (ovf_d) begin
            // drop the oldest frame so the newest data survives
            rp_d = rp_d + SBS_FRAME_STEP;
            cnt_d = cnt_d - SBS_FRAME_CNT;
        end
        if (unf_d) begin
            // the last frame read is still in store: read it again
            rp_d = rp_d - SBS_FRAME_STEP;
            cnt_d = cnt_d + SBS_FRAME_CNT;
        end
        if (bus.rd_en) begin
            rd_data_d = mem_q[rp_d];
            rp_d = rp_d + 6'h01;
            cnt_d = cnt_d - 7'h01;
        end
        if (bus.wr_valid) begin
            wp_d = wp_q + 6'h01;
            cnt_d = cnt_d + 7'h01;
        end
    end

    // one write port over all entries
    genvar gi;
    generate
        for (gi = 0; gi < SBS_DEPTH; gi++) begin : g_entry
            assign mem_d[gi] = (bus.wr_valid && (wp_q == SBS_PTR_W'(gi))) ?
                               bus.wr_data : mem_q[gi];
            always_ff @(posedge clk_i) begin
                mem_q[gi] <= mem_d[gi];
            end
        end
    endgenerate

    // pointer registers; stored data needs no reset
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= SBS_EMPTY_CNT;
            rd_data_q <= '0;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rd_data_q <= rd_data_d;
            ovf_q <= ovf_d;
            unf_q <= unf_d;
        end
    end

    assign bus.rd_data = rd_data_q;
    assign bus.overflow = ovf_q;
    assign bus.underflow = unf_q;
endmodule : sbs_slip_buffer
`default_nettype wire

//--- design/sbs_slip_status.sv
/*
 * sbs_slip_status: slip buffer event flags, multiframe lock report and interrupt.
 * assumes: one 40 MHz clock for all logic, a plain register port,
 * and framer checks that pulse once per received alignment pattern.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_slip_status
    import sbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // transmit slip buffer, backplane writes and line reads
    input wire logic tx_wr_valid_i,
    input wire logic [SBS_DATA_W-1:0] tx_wr_data_i,
    input wire logic tx_rd_en_i,
    output logic [SBS_DATA_W-1:0] tx_rd_data_o,
    // receive slip buffer, line writes and backplane reads
    input wire logic rx_wr_valid_i,
    input wire logic [SBS_DATA_W-1:0] rx_wr_data_i,
    input wire logic rx_rd_en_i,
    output logic [SBS_DATA_W-1:0] rx_rd_data_o,
    // framer alignment checks
    input wire logic cas_align_ok_i,
    input wire logic cas_align_err_i,
    input wire logic crc_align_ok_i,
    input wire logic crc_align_err_i,
    // interrupt
    output logic irq_o
);
    // =========================================================
    // slip buffers
    // =========================================================
    sbs_buf_if tx_bus ();
    sbs_buf_if rx_bus ();

    assign tx_bus.wr_valid = tx_wr_valid_i;
    assign tx_bus.wr_data = tx_wr_data_i;
    assign tx_bus.rd_en = tx_rd_en_i;
    assign tx_rd_data_o = tx_bus.rd_data;
    assign rx_bus.wr_valid = rx_wr_valid_i;
    assign rx_bus.wr_data = rx_wr_data_i;
    assign rx_bus.rd_en = rx_rd_en_i;
    assign rx_rd_data_o = rx_bus.rd_data;

    // transmit buffer: overflow drops a frame, underflow repeats one
    sbs_slip_buffer u_tx_buf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .bus(tx_bus.buffer)
    );

    // receive buffer: its underflow drives no flag and no port
    sbs_slip_buffer u_rx_buf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .bus(rx_bus.buffer)
    );

    // =========================================================
    // configuration registers
    // =========================================================
    logic [7:0] mask_q, mask_d;
    logic [7:0] framing_q, framing_d;
    logic wr_mask, wr_framing, wr_status, rd_status;

    assign wr_mask = reg_wr_i && (reg_addr_i == SBS_ADDR_MASK);
    assign wr_framing = reg_wr_i && (reg_addr_i == SBS_ADDR_FRAMING);
    assign wr_status = reg_wr_i && (reg_addr_i == SBS_ADDR_STATUS);
    assign rd_status = reg_rd_i && (reg_addr_i == SBS_ADDR_STATUS);

    // plain read-write registers
    always_comb begin
        mask_d = wr_mask ? reg_wdata_i : mask_q;
        framing_d = wr_framing ? reg_wdata_i : framing_q;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mask_q <= SBS_RESET_VAL;
            framing_q <= SBS_RESET_VAL;
        end else begin
            mask_q <= mask_d;
            framing_q <= framing_d;
        end
    end

    // =========================================================
    // multiframe lock trackers
    // =========================================================
    logic cas_locked, crc_locked;

    // signaling multiframe; disabled signaling parks it in hunt
    sbs_lock_tracker u_cas_lock (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(framing_q[SBS_FR_CAS_EN]),
        .confirm_sel_i(framing_q[SBS_FR_CAS_SEL]),
        .loss_thr_i(framing_q[SBS_FR_CAS_THR_LO +: SBS_THR_W]),
        .align_ok_i(cas_align_ok_i),
        .align_err_i(cas_align_err_i),
        .locked_o(cas_locked)
    );

    // crc multiframe; same criteria machinery, own settings
    sbs_lock_tracker u_crc_lock (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(framing_q[SBS_FR_CRC_EN]),
        .confirm_sel_i(framing_q[SBS_FR_CRC_SEL]),
        .loss_thr_i(framing_q[SBS_FR_CRC_THR_LO +: SBS_THR_W]),
        .align_ok_i(crc_align_ok_i),
        .align_err_i(crc_align_err_i),
        .locked_o(crc_locked)
    );

    // =========================================================
    // event flags
    // =========================================================
    logic [7:0] flags_q, flags_d;
    logic [7:0] flag_set, flag_clr, status_view;

    // event pulses land on their bit positions
    always_comb begin
        flag_set = '0;
        flag_set[SBS_BIT_TX_OVF] = tx_bus.overflow;
        flag_set[SBS_BIT_TX_UNF] = tx_bus.underflow;
        flag_set[SBS_BIT_TX_SLIP] = tx_bus.overflow | tx_bus.underflow;
        flag_set[SBS_BIT_RX_OVF] = rx_bus.overflow;
    end

    // read clears all sticky bits, a write of one clears single bits
    assign flag_clr = rd_status ? SBS_STICKY_MASK : (wr_status ? reg_wdata_i : 8'h00);

    // set wins over clear so an event in the read cycle shows next read
    always_comb begin
        flags_d = ((flags_q & ~flag_clr) | flag_set) & SBS_STICKY_MASK;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            flags_q <= SBS_RESET_VAL;
        end else begin
            flags_q <= flags_d;
        end
    end

    // lock bits are live, never latched
    always_comb begin
        status_view = flags_q;
        status_view[SBS_BIT_CAS_LOCK] = cas_locked;
        status_view[SBS_BIT_CRC_LOCK] = crc_locked;
    end

    // =========================================================
    // read data and interrupt
    // =========================================================
    logic [7:0] rdata_q, rdata_d;

    // one cycle after the strobe, zero otherwise and for unmapped addresses
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                SBS_ADDR_STATUS: rdata_d = status_view;
                SBS_ADDR_MASK: rdata_d = mask_q;
                SBS_ADDR_FRAMING: rdata_d = framing_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    // only sticky bits interrupt; a lock bit would hold the line forever
    assign irq_o = |(flags_q & mask_q);
endmodule : sbs_slip_status
`default_nettype wire

//--- test/sbs_framer_model.sv
/*
 * sbs_framer_model: line side of the buffers and the framer's pattern checks.
 * assumes: called by the bench through its tasks; one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_framer_model (
    // clock
    input wire logic clk_i,
    // line side of the buffers
    output logic tx_rd_en_o,
    output logic rx_wr_valid_o,
    output logic [7:0] rx_wr_data_o,
    // pattern checks
    output logic [3:0] chk_o
);
    initial begin
        tx_rd_en_o = 1'b0;
        rx_wr_valid_o = 1'b0;
        rx_wr_data_o = 8'h00;
        chk_o = 4'h0;
    end
    // n back to back line reads; the line never waits
    task automatic line_read(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tx_rd_en_o <= 1'b1;
        end
        @(posedge clk_i);
        tx_rd_en_o <= 1'b0;
    endtask : line_read
    task automatic line_write(input logic [7:0] d);
        @(posedge clk_i);
        rx_wr_valid_o <= 1'b1;
        rx_wr_data_o <= d;
        @(posedge clk_i);
        rx_wr_valid_o <= 1'b0;
        rx_wr_data_o <= ~d; // released line shows no stale octet
    endtask : line_write
    // one pattern check pulse: {crc ok, crc err, cas ok, cas err}
    task automatic pattern(input logic crc, input logic good);
        @(posedge clk_i);
        chk_o <= {crc & good, crc & !good, !crc & good, !crc & !good};
        @(posedge clk_i);
        chk_o <= 4'h0;
    endtask : pattern
endmodule : sbs_framer_model
`default_nettype wire

//--- test/sbs_slip_status_sva.sv
/*
 * sbs_slip_status_chk: port-level properties of the slip status block.
 * assumes: bound to sbs_slip_status; one clock, synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_slip_status_chk
    import sbs_pkg::*;
(
    // clock, reset, register port
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // buffer strobes
    input wire logic tx_wr_valid_i,
    input wire logic tx_rd_en_i,
    input wire logic [SBS_DATA_W-1:0] tx_rd_data_o,
    input wire logic rx_wr_valid_i,
    // framer checks, interrupt
    input wire logic cas_align_err_i,
    input wire logic crc_align_ok_i,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // =========================================================
    // helper logic
    // =========================================================
    logic quiet;
    logic st_rd;
    logic [7:0] fr_d;
    logic [7:0] fr_q;
    // no write or transmit read strobe means no flagged slip can be in flight
    assign quiet = !(tx_wr_valid_i || tx_rd_en_i || rx_wr_valid_i);
    assign st_rd = reg_rd_i && reg_addr_i == SBS_ADDR_STATUS;
    // shadow of the framing register, so lock checks know what is enabled
    always_comb begin
        fr_d = fr_q;
        if (reg_wr_i && reg_addr_i == SBS_ADDR_FRAMING) begin
            fr_d = reg_wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        fr_q <= reset_n_i ? fr_d : 8'h00;
    end
    // =========================================================
    // properties
    // =========================================================
    a_slip_implied: assert property ($past(st_rd) && reg_rdata_o[7:6] != 2'b00 |-> reg_rdata_o[5])
        else $error("slip flag missing beside overflow or underflow");
    a_read_clears: assert property (st_rd && quiet && $past(quiet) && $past(quiet, 2)
        ##1 st_rd && quiet |=> (reg_rdata_o & SBS_STICKY_MASK) == 8'h00)
        else $error("sticky flags survived a status read");
    a_cas_loss: assert property (fr_q[SBS_FR_CAS_EN] && fr_q[5:4] == 2'b00 && cas_align_err_i
        ##2 st_rd |=> !reg_rdata_o[SBS_BIT_CAS_LOCK])
        else $error("signaling lock kept after errored pattern");
    a_crc_declare: assert property (fr_q[SBS_FR_CRC_EN] && !fr_q[SBS_FR_CRC_SEL] && crc_align_ok_i
        ##2 st_rd |=> reg_rdata_o[SBS_BIT_CRC_LOCK])
        else $error("crc lock not declared after good pattern");
    a_lock_off: assert property (st_rd && fr_q[1:0] == 2'b00 && $past(fr_q[1:0]) == 2'b00
        |=> reg_rdata_o[4:3] == 2'b00)
        else $error("lock bit set while alignment disabled");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(!quiet, 2) || $past(reg_wr_i)
        || $past(reg_wr_i, 2))
        else $error("interrupt rose with no slip or write");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(reg_rd_i) || $past(reg_wr_i))
        else $error("interrupt fell with no read or write");
    a_rd_hold: assert property (!$past(tx_rd_en_i) |-> $stable(tx_rd_data_o))
        else $error("transmit read data changed without a read");
endmodule : sbs_slip_status_chk

bind sbs_slip_status sbs_slip_status_chk chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_wr_valid_i(tx_wr_valid_i), .tx_rd_en_i(tx_rd_en_i),
    .tx_rd_data_o(tx_rd_data_o), .rx_wr_valid_i(rx_wr_valid_i),
    .cas_align_err_i(cas_align_err_i), .crc_align_ok_i(crc_align_ok_i), .irq_o(irq_o));
`default_nettype wire

//--- test/sbs_slip_status_tb.sv
/*
 * sbs_slip_status_tb: self-checking bench for the slip status block.
 * assumes: sbs_framer_model stands in for the line side and framer.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_slip_status_tb;
    import sbs_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, tx_wr_valid, rx_rd_en, tx_rd_en, rx_wr_valid, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_wr_data, tx_rd_data, rx_wr_data, rx_rd_data;
    logic [3:0] fchk;
    logic [7:0] oct [65];
    logic [7:0] v;
    logic [7:0] w;
    int err_total = 0;
    int n_checks = 0;
    int seed;
    sbs_framer_model fm (.clk_i(clk), .tx_rd_en_o(tx_rd_en), .rx_wr_valid_o(rx_wr_valid),
        .rx_wr_data_o(rx_wr_data), .chk_o(fchk));
    sbs_slip_status dut (.clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .tx_wr_valid_i(tx_wr_valid), .tx_wr_data_i(tx_wr_data), .tx_rd_en_i(tx_rd_en),
        .tx_rd_data_o(tx_rd_data), .rx_wr_valid_i(rx_wr_valid), .rx_wr_data_i(rx_wr_data),
        .rx_rd_en_i(rx_rd_en), .rx_rd_data_o(rx_rd_data), .cas_align_ok_i(fchk[1]),
        .cas_align_err_i(fchk[0]), .crc_align_ok_i(fchk[3]), .crc_align_err_i(fchk[2]),
        .irq_o(irq));
    // 40 MHz
    always #12.5 clk = ~clk;
    // =========================================================
    // tasks and expectations
    // =========================================================
    function automatic logic [7:0] exp_st(input logic ovf, unf, cas, crc, rxo);
        return {ovf, unf, ovf | unf, cas, crc, rxo, 2'b00}; // either slip sets bit 5
    endfunction : exp_st
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // one read, or two back to back if n exceeds 1, of one address, data kept as r0 and r1
    task automatic reg_read(input logic [7:0] a, input int n, output logic [7:0] r0, r1);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        if (n < 2) reg_rd <= 1'b0;
        @(negedge clk);
        r0 = reg_rdata;
        if (n > 1) begin
            @(posedge clk);
            reg_rd <= 1'b0;
            @(negedge clk);
            r1 = reg_rdata;
        end
    endtask : reg_read
    task automatic tx_put(input logic [7:0] d);
        @(posedge clk);
        tx_wr_valid <= 1'b1;
        tx_wr_data <= d;
        @(posedge clk);
        tx_wr_valid <= 1'b0;
        tx_wr_data <= ~d;
    endtask : tx_put
    // flag and interrupt both land two edges after the slip
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask : irq_is
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // =========================================================
    // hang guard
    // =========================================================
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test();
    end
    // =========================================================
    // main sequence
    // =========================================================
    initial begin
        {clk, reset_n, reg_wr, reg_rd, tx_wr_valid, rx_rd_en} = 6'h00;
        {reg_addr, reg_wdata, tx_wr_data} = 24'h000000;
        seed = $urandom(62768);
        foreach (oct[i]) oct[i] = 8'($urandom);
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 8; a < 11; a++) begin
            reg_read(8'(a), 1, v, w);
            chk("reset value", SBS_RESET_VAL, v);
        end
        reg_read(8'h0b + 8'($urandom_range(0, 244)), 1, v, w);
        chk("unmapped", 8'h00, v);
        $display("test reset done");
        // receive overflow masked: flag set, no interrupt
        for (int i = 0; i < 65; i++) fm.line_write(oct[i]);
        irq_is(1'b0);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("status", exp_st(0, 0, 0, 0, 1), v);
        @(posedge clk);
        rx_rd_en <= 1'b1;
        @(posedge clk);
        rx_rd_en <= 1'b0;
        @(negedge clk);
        chk("rx oldest", oct[32], rx_rd_data);
        reg_write(SBS_ADDR_MASK, 8'he4);
        for (int i = 0; i < 33; i++) fm.line_write(oct[i]);
        irq_is(1'b1);
        reg_write(SBS_ADDR_STATUS, 8'h04);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("status", 8'h00, v);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test receive done");
        // transmit overflow then underflow
        for (int i = 0; i < 65; i++) tx_put(oct[i]);
        irq_is(1'b1);
        reg_read(SBS_ADDR_STATUS, 2, v, w);
        chk("status", exp_st(1, 0, 0, 0, 0), v);
        chk("status", 8'h00, w);
        irq_is(1'b0);
        fm.line_read(1);
        @(negedge clk);
        chk("tx after drop", oct[32], tx_rd_data);
        fm.line_read(32);
        @(negedge clk);
        chk("tx last", oct[64], tx_rd_data);
        fm.line_read(1);
        @(negedge clk);
        chk("tx repeat", oct[33], tx_rd_data);
        irq_is(1'b1);
        reg_read(SBS_ADDR_STATUS, 2, v, w);
        chk("status", exp_st(0, 1, 0, 0, 0), v);
        chk("status", 8'h00, w);
        $display("test transmit done");
        // lock: signaling needs two goods and drops on one error, crc locks on one
        reg_write(SBS_ADDR_FRAMING, 8'h47);
        fm.pattern(0, 1);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("lock", exp_st(0, 0, 0, 0, 0), v);
        fm.pattern(0, 1);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("lock", exp_st(0, 0, 1, 0, 0), v);
        fm.pattern(1, 1);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("lock", exp_st(0, 0, 1, 1, 0), v);
        fm.pattern(1, 0);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("lock", exp_st(0, 0, 1, 1, 0), v);
        fm.pattern(1, 0);
        fm.pattern(0, 0);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("lock", exp_st(0, 0, 0, 0, 0), v);
        fm.pattern(1, 1);
        reg_write(SBS_ADDR_FRAMING, 8'h00);
        repeat (2) @(posedge clk);
        reg_read(SBS_ADDR_STATUS, 1, v, w);
        chk("lock", 8'h00, v);
        $display("test lock done");
        end_of_test();
    end
endmodule : sbs_slip_status_tb
`default_nettype wire
